// ### scg_pkg.sv
// constants and carrier types for the serial bit clock generator
// assumes one 250 MHz clock (mclk) and an APB master with 32-bit data
// Behaviour
// - hold-off bit stops clock until first sync
// - divider sync-reset enable gates divider reset
// - sync resets divider if any channel enabled
// - polarity 1: rising edge mid data bit
// - polarity 0: falling edge mid data bit
// - rate code 000 turns clock off
// - rate codes 001..101 divide by 1..16
// - sync resets enabled channels' serial outputs
package scg_pkg;

	// register indices; byte address is four times the index
	localparam logic [31:0] SCG_IDX_SRC    = 32'h0000_f802;
	localparam logic [31:0] SCG_IDX_CTRL   = 32'h0000_f803;
	localparam logic [31:0] SCG_IDX_STATUS = 32'h0000_f810;

	// control register fields
	localparam int SCG_CTRL_RATE_LSB = 0;
	localparam int SCG_CTRL_POL      = 3;
	localparam int SCG_CTRL_DIVSYNC  = 4;
	localparam int SCG_CTRL_HOLDOFF  = 5;
	localparam logic [15:0] SCG_CTRL_MASK  = 16'h003f;
	localparam logic [15:0] SCG_CTRL_RESET = 16'h0000;

	// per-channel serial-output sync enables in the source register
	localparam int SCG_SRC_CH0 = 24;
	localparam int SCG_SRC_CH1 = 16;
	localparam int SCG_SRC_CH2 = 8;
	localparam int SCG_SRC_CH3 = 0;
	localparam logic [31:0] SCG_SRC_RESET = 32'h0000_0000;

	// rate codes
	localparam logic [2:0] SCG_RATE_OFF   = 3'h0;
	localparam logic [2:0] SCG_RATE_DIV1  = 3'h1;
	localparam logic [2:0] SCG_RATE_DIV16 = 3'h5;

	// hold-off flag is armed by every hardware reset
	localparam logic SCG_HOLDOFF_RESET = 1'b1;

	// apb slave answers with no wait states
	localparam int SCG_APB_WAIT_CYCLES = 0;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} scg_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} scg_apb_rsp_s;

	typedef struct packed {
		logic       sclk;
		logic       sclk_bypass;
		logic       bit_strobe;
		logic [3:0] ser_out_rst;
	} scg_ser_s;

endpackage

// ### scg_div.sv
// power-of-two divider that shapes the serial bit clock
// assumes run, restart and shift come from logic on mclk
module scg_div (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// control
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [2:0] shift,
	input  wire logic       pol,
	// outputs
	output logic            sclk,
	output logic            bit_strobe,
	output logic [3:0]      phase
);

	typedef struct packed {
		logic [3:0] cnt;
		logic       running;
		logic       sclk;
		logic       strobe;
	} scg_div_state_s;

	scg_div_state_s st;
	scg_div_state_s next_st;
	logic [3:0]     mask;
	logic [3:0]     half;

	always_comb begin
		mask = 4'((5'h01 << shift) - 5'h01);
		half = 4'((5'h01 << shift) >> 1);
		next_st = st;
		next_st.running = run;
		// a stopped or restarted divider begins a fresh bit at phase zero
		if (restart || !run || !st.running) begin
			next_st.cnt = 4'h0;
		// a lowered rate wraps at once instead of running out the old count
		end else if (st.cnt >= mask) begin
			next_st.cnt = 4'h0;
		end else begin
			next_st.cnt = st.cnt + 4'h1;
		end
		next_st.strobe = run && (next_st.cnt == 4'h0);
		// data changes at phase zero, so the bit centre is at half
		if (!run) begin
			next_st.sclk = 1'b0;
		end else if (pol) begin
			next_st.sclk = (next_st.cnt >= half);
		end else begin
			next_st.sclk = (next_st.cnt < half);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sclk       = st.sclk;
	assign bit_strobe = st.strobe;
	assign phase      = st.cnt;

endmodule

// ### scg_top.sv
// serial bit clock generator with its control registers on APB
// assumes sync_in is asynchronous to mclk; divide-by-1 needs a pad clock mux
module scg_top (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	// register bus
	input  wire scg_pkg::scg_apb_req_s apb_req,
	output scg_pkg::scg_apb_rsp_s      apb_rsp,
	// sync pin
	input  wire logic                  sync_in,
	// serial clock side
	output scg_pkg::scg_ser_s          ser
);

	typedef struct packed {
		logic [15:0] ctrl;
		logic [3:0]  src_en;
		logic        holdoff;
		logic        sync_ff1;
		logic        sync_ff2;
		logic        sync_ff3;
		logic [31:0] prdata;
		logic        pslverr;
		logic [3:0]  ser_rst;
		logic        bypass;
	} scg_top_state_s;

	localparam scg_top_state_s SCG_TOP_RESET = '{
		ctrl:     scg_pkg::SCG_CTRL_RESET,
		src_en:   4'h0,
		holdoff:  scg_pkg::SCG_HOLDOFF_RESET,
		sync_ff1: 1'b0,
		sync_ff2: 1'b0,
		sync_ff3: 1'b0,
		prdata:   32'h0000_0000,
		pslverr:  1'b0,
		ser_rst:  4'h0,
		bypass:   1'b0
	};

	localparam logic [31:0] SCG_ADDR_SRC    = {scg_pkg::SCG_IDX_SRC[29:0], 2'b00};
	localparam logic [31:0] SCG_ADDR_CTRL   = {scg_pkg::SCG_IDX_CTRL[29:0], 2'b00};
	localparam logic [31:0] SCG_ADDR_STATUS = {scg_pkg::SCG_IDX_STATUS[29:0], 2'b00};

	scg_top_state_s st;
	scg_top_state_s next_st;

	logic [2:0]  rate;
	logic        pol;
	logic        divsync_en;
	logic        holdoff_en;
	logic        rate_ok;
	logic [2:0]  shift;
	logic        run;
	logic        sync_pulse;
	logic        div_restart;
	logic        wr_access;
	logic        setup;
	logic [31:0] src_word;
	logic [31:0] status_word;
	logic [31:0] wr_ctrl;
	logic [31:0] wr_src;
	logic        div_sclk;
	logic        div_strobe;
	logic [3:0]  div_phase;

	// byte-lane merge of a write into an existing word
	function automatic logic [31:0] scg_merge(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = wdata[8*i +: 8];
			end
		end
		return res;
	endfunction

	// control fields
	assign rate       = st.ctrl[scg_pkg::SCG_CTRL_RATE_LSB +: 3];
	assign pol        = st.ctrl[scg_pkg::SCG_CTRL_POL];
	assign divsync_en = st.ctrl[scg_pkg::SCG_CTRL_DIVSYNC];
	assign holdoff_en = st.ctrl[scg_pkg::SCG_CTRL_HOLDOFF];

	// undefined rate codes are treated like off rather than guessed at
	assign rate_ok = (rate >= scg_pkg::SCG_RATE_DIV1) && (rate <= scg_pkg::SCG_RATE_DIV16);
	assign shift   = rate - scg_pkg::SCG_RATE_DIV1;

	// clock runs only for a defined rate and outside hold-off
	assign run = rate_ok && !(holdoff_en && st.holdoff);

	// sync edge seen on the synchronised pin
	assign sync_pulse = st.sync_ff2 && !st.sync_ff3;

	// divider reset needs both its enable and some channel enabled
	assign div_restart = sync_pulse && divsync_en && (|st.src_en);

	// apb phases
	assign setup     = apb_req.psel && !apb_req.penable;
	assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;

	// only the serial-output sync enables live here; other bits read zero
	always_comb begin
		src_word = 32'h0000_0000;
		src_word[scg_pkg::SCG_SRC_CH0] = st.src_en[0];
		src_word[scg_pkg::SCG_SRC_CH1] = st.src_en[1];
		src_word[scg_pkg::SCG_SRC_CH2] = st.src_en[2];
		src_word[scg_pkg::SCG_SRC_CH3] = st.src_en[3];
	end

	assign status_word = {24'h00_0000, div_phase, st.holdoff, run, st.bypass, div_sclk};

	assign wr_ctrl = scg_merge({16'h0000, st.ctrl}, apb_req.pwdata, apb_req.pstrb);
	assign wr_src  = scg_merge(src_word, apb_req.pwdata, apb_req.pstrb);

	always_comb begin
		next_st = st;

		// two-stage synchroniser, third stage only for the edge
		next_st.sync_ff1 = sync_in;
		next_st.sync_ff2 = st.sync_ff1;
		next_st.sync_ff3 = st.sync_ff2;

		// first sync after reset ends the hold-off for good
		if (sync_pulse) begin
			next_st.holdoff = 1'b0;
		end

		// per-channel serial output reset, one cycle wide
		next_st.ser_rst = sync_pulse ? st.src_en : 4'h0;

		// divide-by-1 cannot come from flops; flag the pad mux instead
		next_st.bypass = run && (rate == scg_pkg::SCG_RATE_DIV1);

		// read data and error latched in setup, presented in access
		if (setup) begin
			next_st.pslverr = 1'b0;
			case (apb_req.paddr)
				SCG_ADDR_CTRL: begin
					next_st.prdata = {16'h0000, st.ctrl};
				end
				SCG_ADDR_SRC: begin
					next_st.prdata = src_word;
				end
				SCG_ADDR_STATUS: begin
					next_st.prdata = status_word;
				end
				default: begin
					next_st.prdata  = 32'h0000_0000;
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		// writes take effect at the access edge; reserved bits stay zero
		if (wr_access) begin
			case (apb_req.paddr)
				SCG_ADDR_CTRL: begin
					next_st.ctrl = wr_ctrl[15:0] & scg_pkg::SCG_CTRL_MASK;
				end
				SCG_ADDR_SRC: begin
					next_st.src_en = {wr_src[scg_pkg::SCG_SRC_CH3],
						wr_src[scg_pkg::SCG_SRC_CH2],
						wr_src[scg_pkg::SCG_SRC_CH1],
						wr_src[scg_pkg::SCG_SRC_CH0]};
				end
				default: begin
					next_st.ctrl = st.ctrl;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st <= SCG_TOP_RESET;
		end else begin
			st <= next_st;
		end
	end

	scg_div u_div (
		.mclk       (mclk),
		.resetn     (resetn),
		.run        (run),
		.restart    (div_restart),
		.shift      (shift),
		.pol        (pol),
		.sclk       (div_sclk),
		.bit_strobe (div_strobe),
		.phase      (div_phase)
	);

	// bus answer: zero wait states
	assign apb_rsp.prdata  = st.prdata;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && st.pslverr;

	// serial side
	assign ser.sclk        = div_sclk;
	assign ser.sclk_bypass = st.bypass;
	assign ser.bit_strobe  = div_strobe;
	assign ser.ser_out_rst = st.ser_rst;

endmodule

// ### scg_props.sv
// port assertions for scg_top, bound below
// assumes whole-word apb writes
module scg_props (
	input wire logic                  mclk,
	input wire logic                  resetn,
	input wire scg_pkg::scg_apb_req_s apb_req,
	input wire scg_pkg::scg_apb_rsp_s apb_rsp,
	input wire logic                  sync_in,
	input wire scg_pkg::scg_ser_s     ser
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0]  c;
	logic [3:0]  en;
	logic [7:0]  a;
	logic [31:0] d;
	logic        seen, wr, q, s, k;
	assign d = apb_req.pwdata;
	assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign q = a > 8'h04;
	assign s = ser.bit_strobe;
	assign k = ser.sclk;
	// a counts cycles since a ctrl write, so a new rate may settle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			c <= 6'h00;
			en <= 4'h0;
			a <= 8'h00;
			seen <= 1'b0;
		end else begin
			a <= a + {7'h00, a != 8'hff};
			seen <= seen | sync_in;
			if (wr && apb_req.paddr == scg_pkg::SCG_IDX_CTRL << 2) begin
				c <= d[5:0];
				a <= 8'h00;
			end
			if (wr && apb_req.paddr == scg_pkg::SCG_IDX_SRC << 2)
				en <= {d[0], d[8], d[16], d[24]};
		end
	end
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	property p_off; c[2:0] == 3'h0 && q |-> !k && !s; endproperty
	a_off: assert property (p_off) else $error("clock at rate off");
	property p_div16; c[2:0] == 3'h5 && !c[4] && q && s |-> ##16 (s || a < 8'h10); endproperty
	a_div16: assert property (p_div16) else $error("bad period");
	property p_pol; c[2:0] > 3'h1 && c[2:0] < 3'h6 && q && s |-> k == !c[3]; endproperty
	a_pol: assert property (p_pol) else $error("bad level at bit start");
	property p_rise; c[3:0] == 4'hb && q && s |-> ##2 ($rose(k) || a < 8'h03); endproperty
	a_rise: assert property (p_rise) else $error("no mid-bit rise");
	property p_fall; c[3:0] == 4'h3 && q && s |-> ##2 ($fell(k) || a < 8'h03); endproperty
	a_fall: assert property (p_fall) else $error("no mid-bit fall");
	property p_rst; $rose(sync_in) && en != 4'h0 |-> ##[2:6] ser.ser_out_rst == en; endproperty
	a_rst: assert property (p_rst) else $error("no channel reset");
	property p_restart; $rose(sync_in) && c[4] && en != 4'h0 && c[2:0] == 3'h5 |-> ##[2:6] s; endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_hold; c[5] && !seen && q |-> !k && !s && !ser.sclk_bypass; endproperty
	a_hold: assert property (p_hold) else $error("clock before sync");
endmodule

bind scg_top scg_props u_props (.mclk(mclk), .resetn(resetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .sync_in(sync_in), .ser(ser));

// ### scg_rx.sv
// receiver stand-in: counts samples taken at bit centre
// assumes sclk is registered on mclk
module scg_rx (
	// clock side
	input  wire logic        mclk,
	input  wire logic        clr,
	input  wire logic        sclk,
	input  wire logic        pol,
	// result
	output logic      [15:0] n_samp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last;
	always_ff @(posedge mclk) begin
		last <= sclk;
		n_samp <= (clr ? 16'h0000 : n_samp) + {15'h0000, sclk != last && sclk == pol};
	end
endmodule

// ### tb_top.sv
// bench for scg_top: apb master, sync pin, receiver
// assumes every apb access is answered
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] AC = scg_pkg::SCG_IDX_CTRL << 2;
	localparam logic [31:0] AS = scg_pkg::SCG_IDX_SRC << 2;
	logic                  mclk, resetn, sync_in, clr, pol, err;
	logic [15:0]           n_samp;
	logic [31:0]           rd, seed;
	scg_pkg::scg_apb_req_s req;
	scg_pkg::scg_apb_rsp_s rsp;
	scg_pkg::scg_ser_s     ser;
	int                    n_fail, n_checks, n;
	scg_top uut (.mclk(mclk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
		.sync_in(sync_in), .ser(ser));
	scg_rx rx (.mclk(mclk), .clr(clr), .sclk(ser.sclk), .pol(pol), .n_samp(n_samp));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic int edges(int r, int lo);
		return (r < lo) ? 0 : 256 >> (r - 1);
	endfunction
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(int i);
		repeat (i) @(posedge mclk);
	endtask
	task automatic stall(int i);
		n_fail += int'(i > 64);
		if (i > 64) wrap_up();
	endtask
	task automatic apb(logic w, logic [31:0] ad, logic [31:0] wd);
		req <= '{1'b1, 1'b0, w, ad, wd, 4'hf};
		tick(1);
		req.penable <= 1'b1;
		tick(1);
		for (int i = 0; rsp.pready !== 1'b1; i++) begin
			stall(i);
			tick(1);
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		tick(1);
	endtask
	task automatic wstb(output int m);
		for (m = 0; ser.bit_strobe !== 1'b1; m++) begin
			stall(m);
			tick(1);
		end
	endtask
	task automatic count(int len, output int s);
		s = 0;
		repeat (len) begin
			tick(1);
			s += int'(ser.bit_strobe);
		end
	endtask
	task automatic run(logic [2:0] r, logic p);
		apb(1'b1, AC, {28'h0, p, r});
		pol <= p;
		clr <= 1'b1;
		tick(8);
		clr <= 1'b0;
		count(256, n);
		chk("strobes", edges(r, 1), n);
		chk("samples", edges(r, 2), n_samp);
		chk("bypass", 32'(r == scg_pkg::SCG_RATE_DIV1), ser.sclk_bypass);
	endtask
	task automatic sync_case(logic [31:0] ctl, logic [31:0] src, logic rs);
		apb(1'b1, AS, src);
		apb(1'b1, AC, ctl);
		wstb(n);
		tick(5);
		sync_in <= 1'b1;
		wstb(n);
		sync_in <= 1'b0;
		tick(12);
		chk("sync lag", 1, rs ? n > 2 && n < 8 : n == 11);
	endtask
	initial begin
		req = '0;
		resetn = 1'b0;
		sync_in = 1'b0;
		clr = 1'b0;
		pol = 1'b0;
		n_fail = 0;
		n_checks = 0;
		seed = 32'h416173ca;
		tick(4);
		resetn <= 1'b1;
		tick(1);
		apb(1'b0, AC, 32'h0);
		chk("ctrl reset", 32'(scg_pkg::SCG_CTRL_RESET), rd);
		apb(1'b0, 32'h0000_0100, 32'h0);
		chk("unmapped", 32'h1, err);
		for (int i = 0; i < 14; i++) begin
			seed = lfsr(seed);
			if (i < 12)
				run(3'(i % 6), i > 5);
			else
				run(3'(seed % 5 + 1), seed[7]);
		end
		sync_case(32'h0000_000d, 32'h0101_0101, 1'b0);
		sync_case(32'h0000_0015, 32'h0000_0001, 1'b1);
		sync_case(32'h0000_0015, 32'h0000_0000, 1'b0);
		resetn <= 1'b0;
		tick(4);
		resetn <= 1'b1;
		tick(1);
		apb(1'b1, AC, 32'h0000_0022);
		count(40, n);
		chk("held off", 0, n);
		sync_in <= 1'b1;
		tick(4);
		sync_in <= 1'b0;
		tick(8);
		count(32, n);
		chk("released", 16, n);
		wrap_up();
	end
endmodule
